/* File: src/pci_parity_pkg.sv */
// Package of constants and types shared by the bus parity and error control block.
package pci_parity_pkg;
	localparam int AD_WIDTH = 32;
	localparam int CBE_WIDTH = 4;
	// Bit positions of the master parity error flags inside the two status registers.
	localparam int CTRL_STAT_SYS_ERR_BIT = 13;
	localparam int CFG_STAT_PAR_BIT = 8;
	localparam logic [15:0] CTRL_STAT_RESET = 16'h0000;
	localparam logic [15:0] CFG_STAT_RESET = 16'h0000;
	// Delay from a failing address phase to the system-error pulse, in clocks.
	localparam int SERR_DELAY_CYCLES = 2;
	// Least reset length the system must give, in active clocks.
	localparam int MIN_RESET_CYCLES = 10;
	// Clock range the bus side supports, in MHz.
	localparam int CLK_MIN_MHZ = 25;
	localparam int CLK_MAX_MHZ = 33;
	typedef enum logic [1:0] {
		IDLE,
		BURST,
		HALTED
	} master_state_t;
endpackage : pci_parity_pkg

/* File: src/parity_if.sv */
// Interface carrying a sampled bus phase to the parity checker and its verdict back.
`timescale 1ns/1ps
interface parity_if;
	logic [31:0] ad;
	logic [3:0] cbe;
	logic par_in;
	logic check_en;
	logic parity;
	logic error;
	modport calc (
		input ad,
		input cbe,
		input par_in,
		input check_en,
		output parity,
		output error
	);
	modport user (
		output ad,
		output cbe,
		output par_in,
		output check_en,
		input parity,
		input error
	);
endinterface : parity_if

/* File: src/parity_calc.sv */
// Even parity generator and comparator over the address/data and command lines.
`timescale 1ns/1ps
module parity_calc (
	parity_if.calc p
);
	// Every line counts, meaningful or not, so parity is a plain xor of all 36 bits.
	assign p.parity = ^{p.ad, p.cbe};
	// A mismatch with the received bit is an error only when a check is requested.
	assign p.error = p.check_en & (p.parity != p.par_in);
endmodule : parity_calc

/* File: src/pci_parity_error_ctrl.sv */
// Bus-side parity generation, parity error reporting, master halt and bus request.
`timescale 1ns/1ps
module pci_parity_error_ctrl (
	input wire logic clock,
	input wire logic nrst,
	input wire logic [31:0] ad_in,
	input wire logic [3:0] cbe_l_in,
	input wire logic par_in,
	input wire logic irdy_l_in,
	input wire logic trdy_l_in,
	input wire logic frame_l_in,
	input wire logic gnt_l,
	input wire logic ad_driving,
	input wire logic addr_phase,
	input wire logic target_sel,
	input wire logic master_active,
	input wire logic master_need,
	input wire logic parity_resp_en,
	input wire logic serr_en,
	input wire logic sys_err_clear,
	output logic par_out,
	output logic par_oe,
	output logic perr_l_out,
	output logic perr_oe,
	output logic serr_l_out,
	output logic serr_oe,
	output logic req_l,
	output logic req_oe,
	output logic [15:0] controller_status_register,
	output logic [15:0] config_command_status_register,
	output logic halted
);
	typedef struct packed {
		logic [31:0] ad;
		logic [3:0] cbe;
		logic addr;
		logic data;
		logic driving;
		logic tsel;
		logic mact;
		logic par;
		logic par_oe;
		logic perr;
		logic serr;
		logic req;
		logic [15:0] ctrl_stat;
		logic [15:0] cfg_stat;
		pci_parity_pkg::master_state_t mstate;
	} state_t;

	state_t state_reg;
	state_t state_next;
	logic phase_done;
	logic master_err;
	parity_if pif ();

	parity_calc u_parity (
		.p(pif.calc)
	);

	// The checker sees the phase captured one edge earlier, with the bit that arrived now.
	assign pif.ad = state_reg.ad;
	assign pif.cbe = state_reg.cbe;
	assign pif.par_in = par_in;
	assign pif.check_en = (state_reg.addr | state_reg.data) & ~state_reg.driving;

	// A data phase completes only with both readies low at the same edge.
	assign phase_done = ~irdy_l_in & ~trdy_l_in;
	// The role is taken from the captured phase, since the error shows one clock later.
	assign master_err = pif.error & state_reg.data & state_reg.mact;

	// Next-state logic; all sampling happens at the rising edge.
	always_comb begin
		state_next = state_reg;
		state_next.ad = ad_in;
		state_next.cbe = cbe_l_in;
		state_next.addr = addr_phase;
		state_next.data = phase_done & ~addr_phase;
		state_next.driving = ad_driving;
		state_next.tsel = target_sel;
		state_next.mact = master_active;
		// Parity of the value on the lines now is registered, so it stands one clock later.
		state_next.par = ^{ad_in, cbe_l_in};
		state_next.par_oe = ad_driving;
		// Target data parity error: one-clock parity-error strobe.
		state_next.perr = pif.error & state_reg.data & state_reg.tsel & parity_resp_en;
		// Address error pulses system error two clocks after the address phase.
		state_next.serr = pif.error & state_reg.addr & serr_en;
		if (state_reg.serr) begin
			state_next.cfg_stat[15] = 1'b1;
		end
		// Master parity error sets both sticky status bits; the set beats the clear.
		if (master_err) begin
			state_next.ctrl_stat[pci_parity_pkg::CTRL_STAT_SYS_ERR_BIT] = 1'b1;
			state_next.cfg_stat[pci_parity_pkg::CFG_STAT_PAR_BIT] = 1'b1;
		end else if (sys_err_clear) begin
			state_next.ctrl_stat[pci_parity_pkg::CTRL_STAT_SYS_ERR_BIT] = 1'b0;
		end
		case (state_reg.mstate)
			pci_parity_pkg::IDLE: begin
				if (master_err) begin
					state_next.mstate = frame_l_in ? pci_parity_pkg::HALTED
						: pci_parity_pkg::BURST;
				end
			end
			pci_parity_pkg::BURST: begin
				// The burst ends on the final phase, when frame is already released.
				if (frame_l_in & phase_done) begin
					state_next.mstate = pci_parity_pkg::HALTED;
				end
			end
			pci_parity_pkg::HALTED: begin
				if (sys_err_clear & ~master_err) begin
					state_next.mstate = pci_parity_pkg::IDLE;
				end
			end
			default: begin
				state_next.mstate = pci_parity_pkg::IDLE;
			end
		endcase
		// Request is withheld while halted so no new burst can start.
		state_next.req = master_need & (state_next.mstate == pci_parity_pkg::IDLE);
	end

	// Reset returns every field to a constant; pins float meanwhile.
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			state_reg <= '0;
			state_reg.ctrl_stat <= pci_parity_pkg::CTRL_STAT_RESET;
			state_reg.cfg_stat <= pci_parity_pkg::CFG_STAT_RESET;
			state_reg.mstate <= pci_parity_pkg::IDLE;
		end else begin
			state_reg <= state_next;
		end
	end

	// Open-drain pins only ever drive low; enables are off in reset.
	assign par_out = state_reg.par;
	assign par_oe = state_reg.par_oe;
	assign perr_l_out = 1'b0;
	assign perr_oe = state_reg.perr;
	assign serr_l_out = 1'b0;
	assign serr_oe = state_reg.serr;
	assign req_l = ~state_reg.req;
	assign req_oe = nrst;
	assign controller_status_register = state_reg.ctrl_stat;
	assign config_command_status_register = state_reg.cfg_stat;
	assign halted = (state_reg.mstate != pci_parity_pkg::IDLE);
endmodule : pci_parity_error_ctrl

/* File: verif/pci_parity_error_ctrl_assertions.sv */
// Concurrent checks on the ports of the bus parity and error control block.
`timescale 1ns/1ps
module pci_parity_error_ctrl_assertions (
	input wire logic clock,
	input wire logic nrst,
	input wire logic [31:0] ad_in,
	input wire logic [3:0] cbe_l_in,
	input wire logic par_in,
	input wire logic irdy_l_in,
	input wire logic trdy_l_in,
	input wire logic ad_driving,
	input wire logic addr_phase,
	input wire logic target_sel,
	input wire logic parity_resp_en,
	input wire logic serr_en,
	input wire logic master_need,
	input wire logic sys_err_clear,
	input wire logic par_out,
	input wire logic par_oe,
	input wire logic perr_l_out,
	input wire logic perr_oe,
	input wire logic serr_l_out,
	input wire logic serr_oe,
	input wire logic req_l,
	input wire logic [15:0] controller_status_register,
	input wire logic [15:0] config_command_status_register
);
	default clocking @(posedge clock); endclocking
	default disable iff (!nrst);
	// All 36 lines of a phase; parity is judged against this whole word.
	wire logic [35:0] ph = {ad_in, cbe_l_in};
	chk_par_value: assert property (ad_driving |=> par_out == ^$past(ph)) else $error("par");
	chk_par_drive: assert property (ad_driving |=> par_oe) else $error("par_oe");
	chk_perr_target: assert property (!ad_driving && !addr_phase && target_sel
		&& parity_resp_en && !irdy_l_in && !trdy_l_in ##1 par_in != ^$past(ph)
		|=> perr_oe && !perr_l_out) else $error("perr");
	chk_serr_addr: assert property (!ad_driving && addr_phase && serr_en
		##1 par_in != ^$past(ph) |=> serr_oe && !serr_l_out) else $error("serr");
	chk_reset_quiet: assert property ($rose(nrst) |-> !par_oe && !perr_oe && !serr_oe && req_l)
		else $error("reset");
	chk_status_pair: assert property ($rose(config_command_status_register[8])
		|-> controller_status_register[13]) else $error("status");
	chk_req_idle: assert property (!master_need |=> req_l) else $error("req");
	chk_err_sticky: assert property (controller_status_register[13] && !sys_err_clear
		|=> controller_status_register[13]) else $error("sticky");
endmodule : pci_parity_error_ctrl_assertions

/* File: verif/bus_agent_model.sv */
// Far-side bus agent that returns parity for phases the device receives.
`timescale 1ns/1ps
module bus_agent_model (
	input wire logic clock,
	input wire logic [31:0] ad,
	input wire logic [3:0] cbe,
	input wire logic corrupt,
	output logic par
);
	// Parity trails its phase by one clock; corrupt flips it only when a test asks.
	always_ff @(posedge clock) begin
		par <= ^{ad, cbe} ^ corrupt;
	end
endmodule : bus_agent_model

/* File: verif/tb_pci_parity_error_ctrl.sv */
// Self-checking bench for the bus parity and error control block.
`timescale 1ns/1ps
module tb_pci_parity_error_ctrl;
	logic clock, nrst, par_in, frame_l_in, ad_driving, addr_phase, target_sel, master_active;
	logic master_need, sys_err_clear, corrupt, par_out, par_oe, perr_l_out, perr_oe, pv;
	logic serr_l_out, serr_oe, req_l, req_oe, halted, irdy_l_in, trdy_l_in;
	logic [31:0] ad_in;
	logic [3:0] cbe_l_in;
	logic [15:0] controller_status_register, config_command_status_register;
	int errors = 0;
	int cmp_count = 0;
	// Readies are asserted unless a test inserts a wait; grant has no logic behind it.
	pci_parity_error_ctrl dut (.*, .gnt_l(1'h0), .parity_resp_en(1'h1), .serr_en(1'h1));
	bus_agent_model agent (.clock(clock), .ad(ad_in), .cbe(cbe_l_in), .corrupt(corrupt),
		.par(par_in));
	// Clock of 50 ns and a watchdog of 400 cycles, far beyond the roughly 50 cycles used.
	initial begin
		clock = 1'h0;
		forever #25 clock = ~clock;
	end
	initial begin
		#20000;
		errors++;
		finish_test();
	end
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp) begin
			errors++;
			$display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
		end
	endtask : check
	task automatic finish_test();
		if (errors == 0 && cmp_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : finish_test
	// One phase lasting a single cycle; returns while its one-cycle error pulse stands.
	task automatic phase(input logic [31:0] a, input logic ap, ts, ma, drv, bad);
		@(posedge clock);
		{ad_in, addr_phase, target_sel, master_active, ad_driving, corrupt} <= {a, ap, ts, ma, drv, bad};
		@(posedge clock);
		{addr_phase, target_sel, ad_driving, corrupt} <= 4'h0;
		#1 pv = par_out;
		@(posedge clock);
		#1;
	endtask : phase
	task automatic t_gen();
		for (int i = 0; i < 4; i++) begin
			phase(32'(i), 1'h0, 1'h0, 1'h0, 1'h1, 1'h0);
			check(16'(pv), 16'(^{32'(i), cbe_l_in}));
		end
	endtask : t_gen
	task automatic t_errors();
		phase(32'h5, 1'h0, 1'h1, 1'h0, 1'h0, 1'h1);
		check(16'({perr_oe, perr_l_out}), 16'h2);
		phase(32'h5, 1'h0, 1'h1, 1'h0, 1'h0, 1'h0);
		check(16'(perr_oe), 16'h0);
		phase(32'h7, 1'h1, 1'h0, 1'h0, 1'h0, 1'h1);
		check(16'({serr_oe, serr_l_out}), 16'h2);
		// A wait cycle does not complete the phase, so its bad parity is not judged.
		@(posedge clock);
		trdy_l_in <= 1'h1;
		phase(32'h3, 1'h0, 1'h1, 1'h0, 1'h0, 1'h1);
		check(16'(perr_oe), 16'h0);
		@(posedge clock);
		trdy_l_in <= 1'h0;
	endtask : t_errors
	// A bad master read halts after the burst and resumes only once the host clears it.
	task automatic t_master();
		{master_need, frame_l_in} <= 2'h2;
		phase(32'h9, 1'h0, 1'h0, 1'h1, 1'h0, 1'h1);
		check(16'(controller_status_register[13]), 16'h1);
		check(16'(config_command_status_register[8]), 16'h1);
		@(posedge clock);
		frame_l_in <= 1'h1;
		repeat (2) @(posedge clock);
		#1 check(16'({halted, req_l}), 16'h3);
		@(posedge clock);
		sys_err_clear <= 1'h1;
		@(posedge clock);
		sys_err_clear <= 1'h0;
		repeat (3) @(posedge clock);
		#1 check(16'({halted, req_l, controller_status_register[13]}), 16'h0);
	endtask : t_master
	task automatic t_reset();
		@(posedge clock);
		nrst <= 1'h0;
		@(posedge clock);
		#1 check(16'({par_oe, perr_oe, serr_oe, req_oe}), 16'h0);
		check(config_command_status_register, pci_parity_pkg::CFG_STAT_RESET);
	endtask : t_reset
	initial begin
		{nrst, ad_driving, addr_phase, target_sel, master_active, master_need} = 6'h0;
		{sys_err_clear, corrupt, frame_l_in} = 3'h1;
		{irdy_l_in, trdy_l_in} = 2'h0;
		ad_in = 32'h0;
		cbe_l_in = 4'hA;
		repeat (10) @(posedge clock);
		nrst <= 1'h1;
		t_gen();
		t_errors();
		t_master();
		t_reset();
		finish_test();
	end
endmodule : tb_pci_parity_error_ctrl
bind pci_parity_error_ctrl pci_parity_error_ctrl_assertions chk (.*);
